// *** dppr_master.sv ***
`timescale 1ns/100ps
module dppr_master
  import dppr_pkg::*;
(
  // clock
  input  wire logic      core_clk,
  // register port of the device
  output dppr_req_t      netReq,
  input  wire dppr_rsp_t netRsp
);
  initial begin
    netReq = '0;
  end

  // one request per call; the answer is registered on the taking edge and sampled 1 ns later
  task automatic xfer(input logic isWr, input logic [15:0] addr, input logic [15:0] data,
                      output logic [7:0] exc, output logic [15:0] rdata, output logic onTime);
    @(posedge core_clk);
    netReq <= '{rd: ~isWr, wr: isWr, addr: addr, data: data};
    @(posedge core_clk);
    // released lines carry the inverse, so a stale value never passes for a live one
    netReq <= '{rd: 1'b0, wr: 1'b0, addr: ~addr, data: ~data};
    #1;
    onTime = (netRsp.valid === 1'b1);
    exc    = netRsp.exc;
    rdata  = netRsp.data;
  endtask
endmodule

// *** dppr_pkg.sv ***
package dppr_pkg;

  // holding register offsets, one 16-bit word each
  localparam logic [15:0] REG_FIRST                        = 16'h0023;
  localparam logic [15:0] REG_LAST                         = 16'h0037;
  localparam logic [15:0] REG_TARGET_OUTPUT_FREQUENCY      = 16'h0023;
  localparam logic [15:0] REG_ACCEL_TIME_HI                = 16'h0024;
  localparam logic [15:0] REG_ACCEL_TIME_LO                = 16'h0025;
  localparam logic [15:0] REG_ACCEL_TIME_MOTOR2_HI         = 16'h0026;
  localparam logic [15:0] REG_ACCEL_TIME_MOTOR2_LO         = 16'h0027;
  localparam logic [15:0] REG_DECEL_TIME_HI                = 16'h0028;
  localparam logic [15:0] REG_DECEL_TIME_LO                = 16'h0029;
  localparam logic [15:0] REG_DECEL_TIME_MOTOR2_HI         = 16'h002A;
  localparam logic [15:0] REG_DECEL_TIME_MOTOR2_LO         = 16'h002B;
  localparam logic [15:0] REG_RUN_KEY_DIRECTION            = 16'h002C;
  localparam logic [15:0] REG_FREQUENCY_SOURCE_SELECT      = 16'h002D;
  localparam logic [15:0] REG_RUN_COMMAND_SOURCE_SELECT    = 16'h002E;
  localparam logic [15:0] REG_BASE_FREQUENCY               = 16'h002F;
  localparam logic [15:0] REG_BASE_FREQUENCY_MOTOR2        = 16'h0030;
  localparam logic [15:0] REG_MAXIMUM_FREQUENCY            = 16'h0031;
  localparam logic [15:0] REG_MAXIMUM_FREQUENCY_MOTOR2     = 16'h0032;
  localparam logic [15:0] REG_ANALOG_INPUT_SELECT          = 16'h0033;
  localparam logic [15:0] REG_ANALOG_RANGE_START_FREQUENCY = 16'h0034;
  localparam logic [15:0] REG_ANALOG_RANGE_END_FREQUENCY   = 16'h0035;
  localparam logic [15:0] REG_ANALOG_RANGE_START_LEVEL     = 16'h0036;
  localparam logic [15:0] REG_ANALOG_RANGE_END_LEVEL       = 16'h0037;
  localparam logic [15:0] REG_WRITE_ALL_MEMORY             = 16'h0900;

  localparam int          NUM_REGS = 21;
  localparam logic [4:0]  IDX_TARGET   = 5'h00;
  localparam logic [4:0]  IDX_ACC1_HI  = 5'h01;
  localparam logic [4:0]  IDX_ACC1_LO  = 5'h02;
  localparam logic [4:0]  IDX_ACC2_HI  = 5'h03;
  localparam logic [4:0]  IDX_ACC2_LO  = 5'h04;
  localparam logic [4:0]  IDX_DEC1_HI  = 5'h05;
  localparam logic [4:0]  IDX_DEC1_LO  = 5'h06;
  localparam logic [4:0]  IDX_DEC2_HI  = 5'h07;
  localparam logic [4:0]  IDX_DEC2_LO  = 5'h08;
  localparam logic [4:0]  IDX_DIR      = 5'h09;
  localparam logic [4:0]  IDX_FSRC     = 5'h0A;
  localparam logic [4:0]  IDX_RSRC     = 5'h0B;
  localparam logic [4:0]  IDX_BASE1    = 5'h0C;
  localparam logic [4:0]  IDX_BASE2    = 5'h0D;
  localparam logic [4:0]  IDX_MAX1     = 5'h0E;
  localparam logic [4:0]  IDX_MAX2     = 5'h0F;
  localparam logic [4:0]  IDX_AISEL    = 5'h10;
  localparam logic [4:0]  IDX_SF       = 5'h11;
  localparam logic [4:0]  IDX_EF       = 5'h12;
  localparam logic [4:0]  IDX_SL       = 5'h13;
  localparam logic [4:0]  IDX_EL       = 5'h14;

  // value limits
  localparam logic [15:0] FREQ_TENTHS_MAX  = 16'h0FA0;
  localparam logic [31:0] TIME_MIN         = 32'h0000_0001;
  localparam logic [31:0] TIME_MAX         = 32'h0004_93E0;
  localparam logic [31:0] TIME_COARSE      = 32'h0000_2710;
  localparam logic [31:0] TIME_STEP        = 32'h0000_000A;
  localparam logic [15:0] BASE_MIN         = 16'h001E;
  localparam logic [15:0] FREQ_HZ_MAX      = 16'h0190;
  localparam logic [15:0] LEVEL_MAX        = 16'h0064;
  localparam logic [15:0] DIR_MAX          = 16'h0001;
  localparam logic [15:0] FSRC_CODE_NET    = 16'h0003;
  localparam logic [15:0] FSRC_CODE_CALC   = 16'h000A;
  localparam logic [15:0] RSRC_CODE_MIN    = 16'h0001;
  localparam logic [15:0] RSRC_CODE_MAX    = 16'h0003;
  localparam logic [15:0] AISEL_MAX        = 16'h0003;

  // answer codes
  localparam logic [7:0]  EXC_NONE  = 8'h00;
  localparam logic [7:0]  EXC_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_VALUE = 8'h03;

  // reset contents, in index order
  localparam logic [15:0] RST_VAL [NUM_REGS] = '{
    16'h0000, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8,
    16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h0002, 16'h003C, 16'h003C,
    16'h003C, 16'h003C, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064};

  typedef enum logic [2:0] {
    FSRC_KEYPAD_POT, FSRC_TERMINAL, FSRC_TARGET_REG, FSRC_NETWORK, FSRC_CALC
  } dppr_fsrc_t;
  typedef enum logic [1:0] {RSRC_TERMINAL, RSRC_KEYPAD, RSRC_NETWORK} dppr_rsrc_t;
  typedef enum logic [1:0] {
    AMODE_SELECT_TERMINAL, AMODE_SUM, AMODE_VOLT_OR_POT, AMODE_CURR_OR_POT
  } dppr_amode_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] data;
  } dppr_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  exc;
    logic [15:0] data;
  } dppr_rsp_t;

  typedef struct packed {
    logic [15:0] targetFreq;
    logic [31:0] accelTime;
    logic [31:0] accelTimeMotor2;
    logic [31:0] decelTime;
    logic [31:0] decelTimeMotor2;
    logic        runKeyReverse;
    dppr_fsrc_t  freqSource;
    dppr_rsrc_t  runSource;
    logic [15:0] baseFreq;
    logic [15:0] baseFreqMotor2;
    logic [15:0] maxFreq;
    logic [15:0] maxFreqMotor2;
    dppr_amode_t analogMode;
    logic [15:0] rangeStartFreq;
    logic [15:0] rangeEndFreq;
    logic [15:0] rangeStartLevel;
    logic [15:0] rangeEndLevel;
  } dppr_params_t;

endpackage

// *** dppr_regs.sv ***
// How it works
// - target frequency at 0023h, zero or start-frequency up to 4000, both in tenths.
// - motor one acceleration pair 0024h/0025h, 1 to 300000.
// - motor two acceleration pair 0026h/0027h, same range.
// - motor one deceleration pair 0028h/0029h, 1 to 300000.
// - motor two deceleration pair 002Ah/002Bh, same range.
// - times of 10000 or more lose their hundredths digit.
// - run key direction at 002Ch, 0 forward, 1 reverse.
// - frequency source at 002Dh decodes 0..3 and 10.
// - run command source at 002Eh decodes 1..3.
// - motor one base frequency 30 up to motor one maximum.
// - motor two base frequency 30 up to motor two maximum.
// - motor one maximum from its base frequency up to 400.
// - motor two maximum from its base frequency up to 400.
// - analog input select at 0033h decodes four modes.
// - analog start frequency at 0034h, 0 to 4000.
// - analog end frequency at 0035h, 0 to 4000.
// - analog start level at 0036h, 0 to 100.
// - analog end level at 0037h, 0 to 100.
// - write-all-memory command pulses a commit to nonvolatile storage.
`timescale 1ns/100ps
module dppr_regs
  import dppr_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         srst,
  // network register request
  input  wire dppr_req_t    netReq,
  // current start frequency, 0.1 Hz units
  input  wire logic [15:0]  startFreqTenths,
  // network answer
  output dppr_rsp_t         netRsp_ff,
  // settings to the drive
  output dppr_params_t      params_ff,
  output logic              nvmStore_ff
);

  logic [15:0] regs_ff [NUM_REGS];
  logic [15:0] stageHi_ff;
  logic [4:0]  stageIdx_ff;
  logic        stageValid_ff;

  logic [15:0] reqOffset;
  logic        inMap;
  logic [4:0]  reqIdx;
  logic [4:0]  hiIdx;
  logic        isPairHi;
  logic        isPairLo;
  logic [15:0] pairHi;
  logic [31:0] pairRaw;
  logic [31:0] pairMod;
  logic [31:0] pairVal;
  logic [15:0] d;
  logic        legal;
  logic        wrTake;
  logic        wrStage;
  logic        isCommit;

  always_comb begin
    d         = netReq.data;
    reqOffset = netReq.addr - REG_FIRST;
    inMap     = (netReq.addr >= REG_FIRST) && (netReq.addr <= REG_LAST);
    reqIdx    = reqOffset[4:0];
    hiIdx     = reqIdx - 5'h01;
    isPairHi  = inMap && reqIdx >= IDX_ACC1_HI && reqIdx <= IDX_DEC2_HI && reqIdx[0];
    isPairLo  = inMap && reqIdx >= IDX_ACC1_LO && reqIdx <= IDX_DEC2_LO && !reqIdx[0];
    // a low word alone pairs with the stored high word
    if (stageValid_ff && stageIdx_ff == hiIdx) begin
      pairHi = stageHi_ff;
    end else if (isPairLo) begin
      pairHi = regs_ff[hiIdx];
    end else begin
      pairHi = 16'h0000;
    end
    pairRaw = {pairHi, d};
    pairMod = pairRaw % TIME_STEP;
    pairVal = (pairRaw >= TIME_COARSE) ? pairRaw - pairMod : pairRaw;
    case (reqIdx)
      IDX_TARGET: begin
        legal = (d == 16'h0000) || (d >= startFreqTenths && d <= FREQ_TENTHS_MAX);
      end
      IDX_ACC1_HI, IDX_ACC2_HI, IDX_DEC1_HI, IDX_DEC2_HI: begin
        legal = d <= TIME_MAX[31:16];
      end
      IDX_ACC1_LO, IDX_ACC2_LO, IDX_DEC1_LO, IDX_DEC2_LO: begin
        legal = pairRaw >= TIME_MIN && pairRaw <= TIME_MAX;
      end
      IDX_DIR: begin
        legal = d <= DIR_MAX;
      end
      IDX_FSRC: begin
        legal = d <= FSRC_CODE_NET || d == FSRC_CODE_CALC;
      end
      IDX_RSRC: begin
        legal = d >= RSRC_CODE_MIN && d <= RSRC_CODE_MAX;
      end
      IDX_BASE1: begin
        legal = d >= BASE_MIN && d <= regs_ff[IDX_MAX1];
      end
      IDX_BASE2: begin
        legal = d >= BASE_MIN && d <= regs_ff[IDX_MAX2];
      end
      IDX_MAX1: begin
        legal = d >= regs_ff[IDX_BASE1] && d <= FREQ_HZ_MAX;
      end
      IDX_MAX2: begin
        legal = d >= regs_ff[IDX_BASE2] && d <= FREQ_HZ_MAX;
      end
      IDX_AISEL: begin
        legal = d <= AISEL_MAX;
      end
      IDX_SF, IDX_EF: begin
        legal = d <= FREQ_TENTHS_MAX;
      end
      IDX_SL, IDX_EL: begin
        legal = d <= LEVEL_MAX;
      end
      default: begin
        legal = 1'b0;
      end
    endcase
    // a refused write touches nothing
    wrTake   = netReq.wr && inMap && legal && !isPairHi;
    wrStage  = netReq.wr && isPairHi && legal;
    isCommit = netReq.wr && netReq.addr == REG_WRITE_ALL_MEMORY;
  end

  // one flip-flop word per holding register
  for (genvar i = 0; i < NUM_REGS; i++) begin : gEntry
    always_ff @(posedge core_clk) begin
      if (srst) begin
        regs_ff[i] <= RST_VAL[i];
      end else if (wrTake && reqIdx == 5'(i)) begin
        regs_ff[i] <= isPairLo ? pairVal[15:0] : d;
      end else if (wrTake && isPairLo && reqIdx == 5'(i + 1)) begin
        regs_ff[i] <= pairVal[31:16];
      end
    end
  end

  // high word waits here so the pair lands in one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      stageHi_ff    <= 16'h0000;
      stageIdx_ff   <= 5'h00;
      stageValid_ff <= 1'b0;
    end else if (wrStage) begin
      stageHi_ff    <= d;
      stageIdx_ff   <= reqIdx;
      stageValid_ff <= 1'b1;
    end else if (wrTake && isPairLo && stageIdx_ff == hiIdx) begin
      // only the pair that owns the stage consumes it
      stageValid_ff <= 1'b0;
    end
  end

  // one answer per request, the cycle after it
  always_ff @(posedge core_clk) begin
    if (srst) begin
      netRsp_ff <= '0;
    end else begin
      netRsp_ff.valid <= netReq.rd || netReq.wr;
      netRsp_ff.data  <= 16'h0000;
      netRsp_ff.exc   <= EXC_NONE;
      if (netReq.wr) begin
        if (!inMap && !isCommit) begin
          netRsp_ff.exc <= EXC_ADDR;
        end else if (inMap && !legal) begin
          netRsp_ff.exc <= EXC_VALUE;
        end
      end else if (netReq.rd) begin
        if (inMap) begin
          netRsp_ff.data <= regs_ff[reqIdx];
        end else begin
          netRsp_ff.exc <= EXC_ADDR;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      nvmStore_ff <= 1'b0;
    end else begin
      nvmStore_ff <= isCommit;
    end
  end

  // settings trail the holding words by one cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      params_ff <= '0;
    end else begin
      params_ff.targetFreq      <= regs_ff[IDX_TARGET];
      params_ff.accelTime       <= {regs_ff[IDX_ACC1_HI], regs_ff[IDX_ACC1_LO]};
      params_ff.accelTimeMotor2 <= {regs_ff[IDX_ACC2_HI], regs_ff[IDX_ACC2_LO]};
      params_ff.decelTime       <= {regs_ff[IDX_DEC1_HI], regs_ff[IDX_DEC1_LO]};
      params_ff.decelTimeMotor2 <= {regs_ff[IDX_DEC2_HI], regs_ff[IDX_DEC2_LO]};
      params_ff.runKeyReverse   <= regs_ff[IDX_DIR][0];
      params_ff.baseFreq        <= regs_ff[IDX_BASE1];
      params_ff.baseFreqMotor2  <= regs_ff[IDX_BASE2];
      params_ff.maxFreq         <= regs_ff[IDX_MAX1];
      params_ff.maxFreqMotor2   <= regs_ff[IDX_MAX2];
      params_ff.rangeStartFreq  <= regs_ff[IDX_SF];
      params_ff.rangeEndFreq    <= regs_ff[IDX_EF];
      params_ff.rangeStartLevel <= regs_ff[IDX_SL];
      params_ff.rangeEndLevel   <= regs_ff[IDX_EL];
      case (regs_ff[IDX_FSRC][3:0])
        4'h1: params_ff.freqSource <= FSRC_TERMINAL;
        4'h2: params_ff.freqSource <= FSRC_TARGET_REG;
        4'h3: params_ff.freqSource <= FSRC_NETWORK;
        4'hA: params_ff.freqSource <= FSRC_CALC;
        default: params_ff.freqSource <= FSRC_KEYPAD_POT;
      endcase
      case (regs_ff[IDX_RSRC][1:0])
        2'h1: params_ff.runSource <= RSRC_TERMINAL;
        2'h3: params_ff.runSource <= RSRC_NETWORK;
        default: params_ff.runSource <= RSRC_KEYPAD;
      endcase
      case (regs_ff[IDX_AISEL][1:0])
        2'h1: params_ff.analogMode <= AMODE_SUM;
        2'h2: params_ff.analogMode <= AMODE_VOLT_OR_POT;
        2'h3: params_ff.analogMode <= AMODE_CURR_OR_POT;
        default: params_ff.analogMode <= AMODE_SELECT_TERMINAL;
      endcase
    end
  end

  property p_target_over;
    @(posedge core_clk) disable iff (srst)
      netReq.wr && netReq.addr == REG_TARGET_OUTPUT_FREQUENCY && netReq.data > FREQ_TENTHS_MAX
      |=> netRsp_ff.exc == EXC_VALUE && regs_ff[IDX_TARGET] == $past(regs_ff[IDX_TARGET]);
  endproperty
  a_target_over: assert property (p_target_over) else $error("target over range stored");

  property p_acc1_range;
    @(posedge core_clk) disable iff (srst)
      {regs_ff[IDX_ACC1_HI], regs_ff[IDX_ACC1_LO]} >= TIME_MIN &&
      {regs_ff[IDX_ACC1_HI], regs_ff[IDX_ACC1_LO]} <= TIME_MAX;
  endproperty
  a_acc1_range: assert property (p_acc1_range) else $error("accel time out of range");

  property p_acc2_pair;
    @(posedge core_clk) disable iff (srst)
      netReq.wr && netReq.addr == REG_ACCEL_TIME_MOTOR2_LO && netRsp_ff.valid == 1'b0 && legal
      |=> netRsp_ff.exc == EXC_NONE ##0 regs_ff[IDX_ACC2_LO] == $past(pairVal[15:0]);
  endproperty
  a_acc2_pair: assert property (p_acc2_pair) else $error("motor two accel pair lost");

  property p_dec1_range;
    @(posedge core_clk) disable iff (srst)
      {regs_ff[IDX_DEC1_HI], regs_ff[IDX_DEC1_LO]} >= TIME_MIN &&
      {regs_ff[IDX_DEC1_HI], regs_ff[IDX_DEC1_LO]} <= TIME_MAX;
  endproperty
  a_dec1_range: assert property (p_dec1_range) else $error("decel time out of range");

  property p_dec2_range;
    @(posedge core_clk) disable iff (srst)
      {regs_ff[IDX_DEC2_HI], regs_ff[IDX_DEC2_LO]} >= TIME_MIN &&
      {regs_ff[IDX_DEC2_HI], regs_ff[IDX_DEC2_LO]} <= TIME_MAX;
  endproperty
  a_dec2_range: assert property (p_dec2_range) else $error("motor two decel out of range");

  property p_coarse;
    @(posedge core_clk) disable iff (srst)
      params_ff.accelTime >= TIME_COARSE |-> params_ff.accelTime % TIME_STEP == 32'h0;
  endproperty
  a_coarse: assert property (p_coarse) else $error("hundredths kept above 100 s");

  property p_dir;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_DIR] <= DIR_MAX ##1 params_ff.runKeyReverse == $past(regs_ff[IDX_DIR][0]);
  endproperty
  a_dir: assert property (p_dir) else $error("run key direction wrong");

  property p_fsrc;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_FSRC] == FSRC_CODE_CALC |=> params_ff.freqSource == FSRC_CALC;
  endproperty
  a_fsrc: assert property (p_fsrc) else $error("frequency source decode wrong");

  property p_rsrc;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_RSRC] >= RSRC_CODE_MIN && regs_ff[IDX_RSRC] <= RSRC_CODE_MAX;
  endproperty
  a_rsrc: assert property (p_rsrc) else $error("run source code illegal");

  property p_base_max;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_BASE1] >= BASE_MIN && regs_ff[IDX_BASE1] <= regs_ff[IDX_MAX1] &&
      regs_ff[IDX_MAX1] <= FREQ_HZ_MAX;
  endproperty
  a_base_max: assert property (p_base_max) else $error("motor one base or max bad");

  property p_base2_max2;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_BASE2] >= BASE_MIN && regs_ff[IDX_BASE2] <= regs_ff[IDX_MAX2] &&
      regs_ff[IDX_MAX2] <= FREQ_HZ_MAX;
  endproperty
  a_base2_max2: assert property (p_base2_max2) else $error("motor two base or max bad");

  property p_levels;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_SL] <= LEVEL_MAX && regs_ff[IDX_EL] <= LEVEL_MAX &&
      regs_ff[IDX_SF] <= FREQ_TENTHS_MAX && regs_ff[IDX_EF] <= FREQ_TENTHS_MAX;
  endproperty
  a_levels: assert property (p_levels) else $error("analog range value bad");

  property p_commit;
    @(posedge core_clk) disable iff (srst)
      netReq.wr && netReq.addr == REG_WRITE_ALL_MEMORY |=> nvmStore_ff && netRsp_ff.valid
      && netRsp_ff.exc == EXC_NONE;
  endproperty
  a_commit: assert property (p_commit) else $error("write all memory not committed");

  property p_refuse;
    @(posedge core_clk) disable iff (srst)
      netReq.wr && inMap && !legal |=> netRsp_ff.exc == EXC_VALUE &&
      regs_ff[$past(reqIdx)] == $past(regs_ff[reqIdx]);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refused write changed a register");

  property p_base_floor;
    @(posedge core_clk) disable iff (srst)
      netReq.wr && netReq.addr == REG_BASE_FREQUENCY && netReq.data < BASE_MIN
      |=> netRsp_ff.exc == EXC_VALUE && $stable(regs_ff[IDX_BASE1]);
  endproperty
  a_base_floor: assert property (p_base_floor) else $error("low base frequency stored");

  property p_max2_cap;
    @(posedge core_clk) disable iff (srst)
      netReq.wr && netReq.addr == REG_MAXIMUM_FREQUENCY_MOTOR2 && netReq.data > FREQ_HZ_MAX
      |=> netRsp_ff.exc == EXC_VALUE && $stable(regs_ff[IDX_MAX2]);
  endproperty
  a_max2_cap: assert property (p_max2_cap) else $error("motor two maximum over cap");

  property p_rsrc_net;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_RSRC] == RSRC_CODE_MAX |=> params_ff.runSource == RSRC_NETWORK;
  endproperty
  a_rsrc_net: assert property (p_rsrc_net) else $error("network run source not decoded");

  property p_amode_sum;
    @(posedge core_clk) disable iff (srst)
      regs_ff[IDX_AISEL] == 16'h0001 |=> params_ff.analogMode == AMODE_SUM;
  endproperty
  a_amode_sum: assert property (p_amode_sum) else $error("summed analog mode not decoded");

endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb
  import dppr_pkg::*;
;
  logic         core_clk;
  logic         srst;
  logic [15:0]  startFreq;
  dppr_req_t    netReq;
  dppr_rsp_t    netRsp;
  dppr_params_t params;
  logic         nvmStore;
  int           badCount;
  int           nCompared;
  logic [15:0]  a;
  logic [15:0]  lim;

  dppr_regs uut (
    .core_clk        (core_clk),
    .srst            (srst),
    .netReq          (netReq),
    .startFreqTenths (startFreq),
    .netRsp_ff       (netRsp),
    .params_ff       (params),
    .nvmStore_ff     (nvmStore)
  );

  dppr_master mst (
    .core_clk (core_clk),
    .netReq   (netReq),
    .netRsp   (netRsp)
  );

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic conclude();
    if (badCount == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      badCount++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic access(input logic isWr, input logic [15:0] ad, input logic [15:0] d,
                        input logic [7:0] expExc, input logic [15:0] expData);
    logic [7:0]  exc;
    logic [15:0] q;
    logic        onTime;
    mst.xfer(isWr, ad, d, exc, q, onTime);
    check(32'(onTime), 32'h1);
    check(32'(exc), 32'(expExc));
    check(32'(q), 32'(expData));
  endtask

  task automatic wr(input logic [15:0] ad, input logic [15:0] d, input logic [7:0] e);
    access(1'b1, ad, d, e, 16'h0000);
  endtask

  task automatic rd(input logic [15:0] ad, input logic [15:0] q);
    access(1'b0, ad, 16'h0000, (q === 16'hFFFF) ? EXC_ADDR : EXC_NONE,
           (q === 16'hFFFF) ? 16'h0000 : q);
  endtask

  // params follow the holding words one cycle late
  task automatic settle();
    @(posedge core_clk);
    #1;
  endtask

  // a run that never reaches its end is stopped after 30000 cycles and fails
  initial begin
    for (int i = 0; i < 30000; i++) begin
      @(posedge core_clk);
    end
    badCount++;
    conclude();
  end

  initial begin
    badCount  = 0;
    nCompared = 0;
    srst      = 1'b1;
    startFreq = 16'h0032;
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) rd(REG_FIRST + 16'(i), RST_VAL[i]);
    settle();
    check(params.accelTime, 32'(RST_VAL[2]));
    rd(16'h0022, 16'hFFFF);
    rd(16'h0038, 16'hFFFF);
    rd(REG_WRITE_ALL_MEMORY, 16'hFFFF);
    wr(16'h0038, 16'h0001, EXC_ADDR);
    // target: zero, or start frequency up to the ceiling
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0FA1, EXC_VALUE);
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0031, EXC_VALUE);
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0032, EXC_NONE);
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0000, EXC_NONE);
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0FA0, EXC_NONE);
    settle();
    check(32'(params.targetFreq), 32'h0FA0);
    // a higher start frequency raises the floor
    @(posedge core_clk);
    startFreq <= 16'h0064;
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0063, EXC_VALUE);
    wr(REG_TARGET_OUTPUT_FREQUENCY, 16'h0064, EXC_NONE);
    rd(REG_TARGET_OUTPUT_FREQUENCY, 16'h0064);
    // time pairs: staging, limits and the coarse step above 100 s
    for (int p = 0; p < 4; p++) begin
      a = REG_ACCEL_TIME_HI + 16'(2 * p);
      wr(a, 16'h0005, EXC_VALUE);
      wr(a, 16'h0001, EXC_NONE);
      rd(a, 16'h0000);
      wr(a + 16'h1, 16'h2345, EXC_NONE);
      rd(a, 16'h0001);
      rd(a + 16'h1, 16'h2340);
      wr(a, 16'h0004, EXC_NONE);
      wr(a + 16'h1, 16'h93E1, EXC_VALUE);
      wr(a + 16'h1, 16'h93E0, EXC_NONE);
      rd(a + 16'h1, 16'h93E0);
      wr(a, 16'h0000, EXC_NONE);
      wr(a + 16'h1, 16'h270F, EXC_NONE);
      rd(a + 16'h1, 16'h270F);
      wr(a, 16'h0000, EXC_NONE);
      wr(a + 16'h1, 16'h0000, EXC_VALUE);
      wr(a + 16'h1, 16'h2715, EXC_NONE);
      rd(a + 16'h1, 16'h2710);
    end
    settle();
    check(params.accelTime, 32'h2710);
    check(params.accelTimeMotor2, 32'h2710);
    check(params.decelTime, 32'h2710);
    check(params.decelTimeMotor2, 32'h2710);
    // a stray write between the halves leaves the stage alone; another pair's high replaces it
    wr(REG_ACCEL_TIME_HI, 16'h0002, EXC_NONE);
    wr(REG_RUN_KEY_DIRECTION, 16'h0001, EXC_NONE);
    wr(REG_ACCEL_TIME_LO, 16'h0000, EXC_NONE);
    rd(REG_ACCEL_TIME_LO, 16'hFFFE);
    wr(REG_ACCEL_TIME_HI, 16'h0003, EXC_NONE);
    wr(REG_ACCEL_TIME_MOTOR2_HI, 16'h0001, EXC_NONE);
    wr(REG_ACCEL_TIME_LO, 16'h0010, EXC_NONE);
    rd(REG_ACCEL_TIME_LO, 16'h000E);
    wr(REG_ACCEL_TIME_MOTOR2_LO, 16'h0000, EXC_NONE);
    settle();
    check(params.accelTime, 32'h0001_000E);
    check(params.accelTimeMotor2, 32'h0000_FFFA);
    check(32'(params.runKeyReverse), 32'h1);
    wr(REG_RUN_KEY_DIRECTION, 16'h0002, EXC_VALUE);
    wr(REG_RUN_KEY_DIRECTION, 16'h0000, EXC_NONE);
    settle();
    check(32'(params.runKeyReverse), 32'h0);
    for (int k = 0; k < 5; k++) begin
      wr(REG_FREQUENCY_SOURCE_SELECT, (k == 4) ? FSRC_CODE_CALC : 16'(k), EXC_NONE);
      settle();
      check(32'(params.freqSource), 32'(k));
    end
    wr(REG_FREQUENCY_SOURCE_SELECT, 16'h0004, EXC_VALUE);
    wr(REG_FREQUENCY_SOURCE_SELECT, 16'h000B, EXC_VALUE);
    for (int k = 1; k < 4; k++) begin
      wr(REG_RUN_COMMAND_SOURCE_SELECT, 16'(k), EXC_NONE);
      settle();
      check(32'(params.runSource), 32'(k - 1));
    end
    wr(REG_RUN_COMMAND_SOURCE_SELECT, 16'h0000, EXC_VALUE);
    wr(REG_RUN_COMMAND_SOURCE_SELECT, 16'h0004, EXC_VALUE);
    for (int k = 0; k < 4; k++) begin
      wr(REG_ANALOG_INPUT_SELECT, 16'(k), EXC_NONE);
      settle();
      check(32'(params.analogMode), 32'(k));
    end
    wr(REG_ANALOG_INPUT_SELECT, 16'h0004, EXC_VALUE);
    // base and maximum hold each other in check, per motor
    for (int m = 0; m < 2; m++) begin
      a = REG_BASE_FREQUENCY + 16'(m);
      wr(a, 16'h001D, EXC_VALUE);
      wr(a, 16'h003D, EXC_VALUE);
      wr(a + 16'h2, 16'h0191, EXC_VALUE);
      wr(a + 16'h2, 16'h0190, EXC_NONE);
      wr(a, 16'h001E, EXC_NONE);
      wr(a + 16'h2, 16'h001D, EXC_VALUE);
      wr(a + 16'h2, 16'h001E, EXC_NONE);
      rd(a + 16'h2, 16'h001E);
    end
    settle();
    check(32'(params.maxFreq), 32'h001E);
    check(32'(params.baseFreqMotor2), 32'h001E);
    check(32'(params.baseFreq), 32'h001E);
    check(32'(params.maxFreqMotor2), 32'h001E);
    for (int i = 0; i < 4; i++) begin
      a   = REG_ANALOG_RANGE_START_FREQUENCY + 16'(i);
      lim = (i < 2) ? FREQ_TENTHS_MAX : LEVEL_MAX;
      wr(a, lim + 16'h1, EXC_VALUE);
      wr(a, lim, EXC_NONE);
      rd(a, lim);
    end
    settle();
    check(32'(params.rangeStartFreq), 32'h0FA0);
    check(32'(params.rangeEndLevel), 32'h0064);
    check(32'(params.rangeEndFreq), 32'h0FA0);
    check(32'(params.rangeStartLevel), 32'h0064);
    wr(REG_WRITE_ALL_MEMORY, 16'hABCD, EXC_NONE);
    check(32'(nvmStore), 32'h1);
    settle();
    check(32'(nvmStore), 32'h0);
    // a second reset in mid-run brings the defaults back
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    rd(REG_TARGET_OUTPUT_FREQUENCY, RST_VAL[0]);
    rd(REG_MAXIMUM_FREQUENCY, RST_VAL[14]);
    conclude();
  end
endmodule
